// >>> verilog/phy_ports_cfg.svh
// Offsets, fields, reset values, codes and timing counts of the physical layer port block
// Operation
// - Insert ackID into every outgoing packet, and CRC into each one not discarded, before the lanes.
// - Device keeps all rx byte qualifiers high except on the final beat.
// - First beat user bit 1 carries the critical flow flag when enabled.
// - Tx packet with user bit 0 on its last beat is discarded.
// - Device flags a bad received packet with user bit 0 on its last beat.
// - Host role output copies the host control bit.
// - Request permit output copies master enable; low means responses only.
// - Long symbol mode flag marks long symbols and six-bit ackIDs.
// - On retransmit request the buffer unit resends from next packet index.
// - Next packet index steps by one per sent packet that is not discarded, backwards only on rewind.
// - Last accepted index is the ackID of the latest acknowledge symbol.
// - Partner free slots come from the latest received status symbol.
// - One K flag per transmit byte, bit i for byte i.
// - One transmit disable bit per lane.
// - Transceiver reset request is honoured by driving the transceiver reset.
// - Device drives bonding enable and judges alignment from lane flags.
// - Settings reset returns all configuration registers to defaults.
`ifndef PHY_PORTS_CFG_SVH
`define PHY_PORTS_CFG_SVH

`define LANES      2
`define OFS_CTRL   8'h00
`define OFS_STAT   8'h04
`define OFS_INDEX  8'h08
`define OFS_FAULT  8'h0c
`define CTRL_RST   32'h0000_0018
`define CTRL_MASK  32'h0000_031f
`define B_HOST     0
`define B_MEN      1
`define B_LONG     2
`define B_CRIT     3
`define B_BOND     4
`define B_DIS      8
`define B_XRST     16
`define K_CTRL     8'h7c
`define K_EOP      8'hfd
`define K_STOMP    8'hfe
`define KC_CTRL    8'hf0
`define KC_EOP     8'h80
`define SYM_ACK    8'h00
`define SYM_NACK   8'h01
`define SYM_STATUS 8'h02
`define KEEP_FULL  8'hff
`define CRC_INIT   16'hffff
`define CRC_POLY   16'h1021
`define CLK_NS     50
`define XRST_NS    500
`define XRST_CYC   ((`XRST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> verilog/phy_ports_pkg.sv
// Types of the physical layer port block
`default_nettype none
package phy_ports_pkg;
  typedef enum logic [1:0] {LNK_RESET, LNK_WAIT_DONE, LNK_ALIGN, LNK_ACTIVE} link_state_t;
endpackage
`default_nettype wire

// >>> verilog/level_sync3.sv
// Three-stage level synchroniser with agreement filter
`default_nettype none
module level_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
endmodule // level_sync3
`default_nettype wire

// >>> verilog/crc16_step.sv
// CRC-16 update over one 64-bit beat, most significant bit first
`default_nettype none
`include "phy_ports_cfg.svh"
module crc16_step (
  input  wire logic [15:0] crc_in,
  input  wire logic [63:0] data,
  output logic      [15:0] crc_out
);
  logic [15:0] c;
  logic        fb;

  always_comb
  begin
    c  = crc_in;
    fb = 1'b0;
    for (int i = 63; i >= 0; i--)
    begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
    crc_out = c;
  end
endmodule // crc16_step
`default_nettype wire

// >>> verilog/serial_link_phy_ports.sv
// Physical layer port block: register slave, lane bring-up, tx framing, rx deframing
`default_nettype none
`include "phy_ports_cfg.svh"
module serial_link_phy_ports (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        settings_port_reset,
  input  wire logic        txin_tvalid,
  output logic             txin_tready,
  input  wire logic [63:0] txin_tdata,
  input  wire logic [7:0]  txin_tkeep,
  input  wire logic        txin_tlast,
  input  wire logic [7:0]  txin_tuser,
  output logic             rxout_tvalid,
  input  wire logic        rxout_tready,
  output logic      [63:0] rxout_tdata,
  output logic      [7:0]  rxout_tkeep,
  output logic             rxout_tlast,
  output logic      [7:0]  rxout_tuser,
  output logic             host_role_flag,
  output logic             request_issue_permit,
  output logic             long_symbol_mode_flag,
  output logic             retransmit_request,
  output logic      [5:0]  next_packet_index,
  output logic      [5:0]  last_accepted_index,
  output logic      [5:0]  partner_free_slots,
  input  wire logic [5:0]  local_free_slots,
  output logic      [63:0] lane_tx_word,
  output logic      [7:0]  lane_tx_kchar_flags,
  output logic      [1:0]  lane_tx_disable,
  input  wire logic [63:0] lane_rx_word,
  input  wire logic [7:0]  lane_rx_kchar_flags,
  input  wire logic [7:0]  lane_rx_disparity_fault,
  input  wire logic [7:0]  lane_rx_decode_fault,
  input  wire logic [1:0]  lane_bond_sequence_seen,
  input  wire logic [1:0]  lane_bonded_flag,
  output logic             bonding_enable_out,
  input  wire logic        transceiver_reset_request,
  output logic             transceiver_reset_out,
  input  wire logic [1:0]  transceiver_reset_complete
);
  phy_ports_pkg::link_state_t st_r;
  logic        a_ph, wr_en_r, wr_ctrl, wr_fault, xrst_cmd, xrst_go, req_prev_r;
  logic [7:0]  addr_r;
  logic [31:0] ctrl_r, hrdata_r;
  logic [6:0]  sync_q;
  logic        req_s, active;
  logic [1:0]  done_s, bond_s, seq_s, fault_r, fault_clr, fault_set;
  logic [3:0]  rst_cnt_r;
  logic [5:0]  ack_mask, next_idx_r, last_acc_r, partner_r;
  logic        tx_fire, tx_first_r, tx_due_r, tx_stomp_r, tx_good_end, retx_r;
  logic [7:0]  tx_keep_r;
  logic [15:0] tx_crc_r, crc_cur, crc_next;
  logic [63:0] tx_beat, idle_word, word_r, buf_r, out_data_r;
  logic [7:0]  kchar_r, rx_f, out_keep_r, out_user_r, push_keep;
  logic        rx_ctrl, rx_eop, rx_data, nack_now, ack_now, stat_now;
  logic        buf_v_r, buf_first_r, rx_first_r, rx_bad_r, out_v_r, out_last_r;
  logic        push_data, push_last, push, out_free, stall, push_bad;

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign a_ph      = hsel && hready && htrans[1];
  assign wr_ctrl   = wr_en_r && (addr_r == `OFS_CTRL);
  assign wr_fault  = wr_en_r && (addr_r == `OFS_FAULT);
  assign xrst_cmd  = wr_ctrl && hwdata[`B_XRST];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_en_r <= 1'b0;
      addr_r  <= 8'h00;
    end
    else
    begin
      wr_en_r <= a_ph && hwrite;
      if (a_ph)
        addr_r <= haddr[7:0];
    end

  // Read data is latched at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (a_ph && !hwrite)
      case (haddr[7:0])
        `OFS_CTRL:  hrdata_r <= ctrl_r;
        `OFS_STAT:  hrdata_r <= {23'h00_0000, req_s, seq_s, bond_s, done_s, st_r};
        `OFS_INDEX: hrdata_r <= {8'h00, 2'h0, partner_r, 2'h0, last_acc_r, 2'h0, next_idx_r};
        `OFS_FAULT: hrdata_r <= {30'h0000_0000, fault_r};
        default:    hrdata_r <= 32'h0000_0000;
      endcase

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctrl_r <= `CTRL_RST;
    else if (settings_port_reset)
      ctrl_r <= `CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= hwdata & `CTRL_MASK;

  assign host_role_flag        = ctrl_r[`B_HOST];
  assign request_issue_permit  = ctrl_r[`B_MEN];
  assign long_symbol_mode_flag = ctrl_r[`B_LONG];
  assign bonding_enable_out    = ctrl_r[`B_BOND];
  assign lane_tx_disable       = ctrl_r[`B_DIS +: `LANES];
  assign ack_mask              = ctrl_r[`B_LONG] ? 6'h3f : 6'h1f;

  // Lane status flags come from the transceiver side
  level_sync3 #(.W(7)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({transceiver_reset_request, transceiver_reset_complete, lane_bonded_flag, lane_bond_sequence_seen}),
    .q     (sync_q)
  );
  assign req_s  = sync_q[6];
  assign done_s = sync_q[5:4];
  assign bond_s = sync_q[3:2];
  assign seq_s  = sync_q[1:0];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      req_prev_r <= 1'b0;
    else
      req_prev_r <= req_s;

  assign xrst_go = (req_s && !req_prev_r) || xrst_cmd;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rst_cnt_r <= 4'(`XRST_CYC);
    else if (xrst_go)
      rst_cnt_r <= 4'(`XRST_CYC);
    else if (rst_cnt_r != 4'h0)
      rst_cnt_r <= rst_cnt_r - 4'h1;

  // Bring-up: reset pulse, wait for all lanes, then bonding
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      st_r <= phy_ports_pkg::LNK_RESET;
    else if (xrst_go)
      st_r <= phy_ports_pkg::LNK_RESET;
    else
      unique case (st_r)
        phy_ports_pkg::LNK_RESET:
          if (rst_cnt_r == 4'h0)
            st_r <= phy_ports_pkg::LNK_WAIT_DONE;
        phy_ports_pkg::LNK_WAIT_DONE:
          if (&done_s)
            st_r <= phy_ports_pkg::LNK_ALIGN;
        phy_ports_pkg::LNK_ALIGN:
          if (!(&done_s))
            st_r <= phy_ports_pkg::LNK_WAIT_DONE;
          else if (!bonding_enable_out || (&bond_s))
            st_r <= phy_ports_pkg::LNK_ACTIVE;
        phy_ports_pkg::LNK_ACTIVE:
          if (!(&done_s))
            st_r <= phy_ports_pkg::LNK_WAIT_DONE;
          else if (bonding_enable_out && !(&bond_s))
            st_r <= phy_ports_pkg::LNK_ALIGN;
      endcase

  assign active                = (st_r == phy_ports_pkg::LNK_ACTIVE);
  assign transceiver_reset_out = (st_r == phy_ports_pkg::LNK_RESET);

  // Transmit framing; no new beat while the trailer is due
  assign txin_tready = active && !tx_due_r;
  assign tx_fire     = txin_tvalid && txin_tready;
  assign tx_beat     = tx_first_r ? {next_idx_r, ctrl_r[`B_CRIT] & txin_tuser[1], txin_tdata[56:0]}
                                  : txin_tdata;
  assign crc_cur     = tx_first_r ? `CRC_INIT : tx_crc_r;
  assign tx_good_end = active && tx_due_r && !tx_stomp_r;
  // Idle words advertise the local free slot estimate as-is
  assign idle_word   = {`K_CTRL, `SYM_STATUS, 2'h0, next_idx_r, 2'h0, local_free_slots, 32'h0000_0000};

  crc16_step u_crc (
    .crc_in  (crc_cur),
    .data    (tx_beat),
    .crc_out (crc_next)
  );

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_first_r <= 1'b1;
      tx_due_r   <= 1'b0;
      tx_stomp_r <= 1'b0;
      tx_keep_r  <= 8'h00;
      tx_crc_r   <= `CRC_INIT;
    end
    else if (!active)
    begin
      tx_first_r <= 1'b1;
      tx_due_r   <= 1'b0;
    end
    else if (tx_fire)
    begin
      tx_crc_r   <= crc_next;
      tx_first_r <= txin_tlast;
      if (txin_tlast)
      begin
        tx_due_r   <= 1'b1;
        tx_stomp_r <= txin_tuser[0];
        tx_keep_r  <= txin_tkeep;
      end
    end
    else
      tx_due_r <= 1'b0;

  // A discontinued packet ends in a stomp so the far end throws it away
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      word_r  <= 64'h0000_0000_0000_0000;
      kchar_r <= 8'h00;
    end
    else if (active && tx_due_r)
    begin
      kchar_r <= `KC_EOP;
      if (tx_stomp_r)
        word_r <= {`K_STOMP, 56'h0};
      else
        word_r <= {`K_EOP, tx_keep_r, tx_crc_r, 32'h0000_0000};
    end
    else if (tx_fire)
    begin
      word_r  <= tx_beat;
      kchar_r <= 8'h00;
    end
    else
    begin
      word_r  <= idle_word;
      kchar_r <= `KC_CTRL;
    end

  assign lane_tx_word        = word_r;
  assign lane_tx_kchar_flags = kchar_r;

  // Receive symbol decode; rx lanes are phase aligned to hclk, so no crossing
  assign rx_f     = lane_rx_disparity_fault | lane_rx_decode_fault;
  assign rx_ctrl  = active && (lane_rx_kchar_flags == `KC_CTRL) && (lane_rx_word[63:56] == `K_CTRL) && !(|rx_f);
  assign rx_eop   = active && (lane_rx_kchar_flags == `KC_EOP) && (lane_rx_word[63:56] == `K_EOP);
  assign rx_data  = active && (lane_rx_kchar_flags == 8'h00);
  assign nack_now = rx_ctrl && (lane_rx_word[55:48] == `SYM_NACK);
  assign ack_now  = rx_ctrl && (lane_rx_word[55:48] == `SYM_ACK);
  assign stat_now = rx_ctrl && (lane_rx_word[55:48] == `SYM_STATUS);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      last_acc_r <= 6'h00;
      partner_r  <= 6'h00;
    end
    else
    begin
      if (ack_now)
        last_acc_r <= lane_rx_word[45:40] & ack_mask;
      if (stat_now)
        partner_r <= lane_rx_word[37:32];
    end

  // Rewind resumes after the last accepted packet
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      next_idx_r <= 6'h00;
      retx_r     <= 1'b0;
    end
    else
    begin
      retx_r <= nack_now;
      if (nack_now)
        next_idx_r <= (last_acc_r + 6'h01) & ack_mask;
      else if (tx_good_end)
        next_idx_r <= (next_idx_r + 6'h01) & ack_mask;
    end

  assign next_packet_index   = next_idx_r;
  assign retransmit_request  = retx_r;
  assign last_accepted_index = last_acc_r;
  assign partner_free_slots  = partner_r;

  // One beat is held back so the end symbol can mark the last one
  assign push_data = buf_v_r && rx_data;
  assign push_last = buf_v_r && (rx_eop || !active);
  assign push      = push_data || push_last;
  assign out_free  = !out_v_r || rxout_tready;
  assign stall     = push && !out_free;
  assign push_bad  = rx_bad_r || (|rx_f) || !active;
  assign push_keep = (push_last && active) ? lane_rx_word[55:48] : `KEEP_FULL;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      buf_r       <= 64'h0000_0000_0000_0000;
      buf_v_r     <= 1'b0;
      buf_first_r <= 1'b0;
      rx_first_r  <= 1'b1;
    end
    else if (rx_data)
    begin
      buf_r       <= lane_rx_word;
      buf_v_r     <= 1'b1;
      buf_first_r <= rx_first_r;
      rx_first_r  <= 1'b0;
    end
    else if (rx_eop || !active)
    begin
      buf_v_r    <= 1'b0;
      rx_first_r <= 1'b1;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rx_bad_r <= 1'b0;
    else if (push_last)
      rx_bad_r <= 1'b0;
    else if ((rx_data && (|rx_f)) || stall)
      rx_bad_r <= 1'b1;

  // A stalled end symbol drops the held beat and marks the output beat last rather than lose framing
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      out_v_r    <= 1'b0;
      out_data_r <= 64'h0000_0000_0000_0000;
      out_keep_r <= 8'h00;
      out_last_r <= 1'b0;
      out_user_r <= 8'h00;
    end
    else if (push && out_free)
    begin
      out_v_r    <= 1'b1;
      out_data_r <= buf_r;
      out_keep_r <= push_keep;
      out_last_r <= push_last;
      out_user_r <= {6'h00, buf_first_r & ctrl_r[`B_CRIT] & buf_r[57], push_last & push_bad};
    end
    else if (stall && push_last)
    begin
      out_last_r    <= 1'b1;
      out_user_r[0] <= 1'b1;
    end
    else if (rxout_tready)
      out_v_r <= 1'b0;

  assign rxout_tvalid = out_v_r;
  assign rxout_tdata  = out_data_r;
  assign rxout_tkeep  = out_keep_r;
  assign rxout_tlast  = out_last_r;
  assign rxout_tuser  = out_user_r;

  // Sticky faults: set wins over a write-one clear
  assign fault_set = {stall, rx_data && (|rx_f)};
  assign fault_clr = wr_fault ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      fault_r <= 2'h0;
    else
      fault_r <= (fault_r & ~fault_clr) | fault_set;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_host_copy: assert property (wr_ctrl && !settings_port_reset |=> host_role_flag == $past(hwdata[`B_HOST]))
    else $error("host role flag does not follow control write");
  a_permit_copy: assert property (wr_ctrl && !settings_port_reset |=> request_issue_permit == $past(hwdata[`B_MEN]))
    else $error("request permit does not follow control write");
  a_cfg_default: assert property (settings_port_reset |=> ctrl_r == `CTRL_RST && !request_issue_permit)
    else $error("settings reset left configuration changed");
  a_rx_keep_full: assert property (rxout_tvalid && !rxout_tlast |-> rxout_tkeep == `KEEP_FULL)
    else $error("non-final rx beat has partial byte qualifier");
  a_index_step: assert property (tx_good_end && !nack_now |=> next_packet_index == (($past(next_packet_index) + 6'h01) & $past(ack_mask)))
    else $error("next packet index did not step by one");
  a_discard_hold: assert property (active && tx_due_r && tx_stomp_r && !nack_now |=> $stable(next_packet_index))
    else $error("discarded packet advanced the index");
  a_crc_trailer: assert property (tx_fire && txin_tlast && !txin_tuser[0] ##1 active |=> lane_tx_kchar_flags == `KC_EOP && lane_tx_word[63:56] == `K_EOP)
    else $error("packet end without crc trailer");
  a_data_kchar: assert property (tx_fire |=> lane_tx_kchar_flags == 8'h00 && lane_tx_word == $past(tx_beat))
    else $error("data beat sent with K flags or wrong word");
  a_ack_index: assert property (ack_now |=> last_accepted_index == ($past(lane_rx_word[45:40]) & $past(ack_mask)))
    else $error("last accepted index not taken from acknowledge");
  a_partner_slots: assert property (stat_now |=> partner_free_slots == $past(lane_rx_word[37:32]))
    else $error("partner free slots not taken from status");
  a_xrst_pulse: assert property (xrst_go |=> transceiver_reset_out [*8])
    else $error("transceiver reset pulse too short");
  a_hold_init: assert property (!(&done_s) |=> !txin_tready)
    else $error("link active before lanes finished reset");
  a_bond_wait: assert property (bonding_enable_out && !(&bond_s) |=> !txin_tready)
    else $error("link active without lane alignment");

  c_packet_sent: cover property (tx_good_end);
  c_rewind: cover property (nack_now ##1 retransmit_request);
  c_rx_stall: cover property (stall);
  c_rx_discard: cover property (rxout_tvalid && rxout_tlast && rxout_tuser[0]);
endmodule // serial_link_phy_ports
`default_nettype wire

// >>> tb/lane_ctrl_model.sv
// Transceiver control model: reset handshake, bonding flags, reset request
`default_nettype none
module lane_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       xrst,
  input  wire logic       req_in,
  output logic      [1:0] done,
  output logic      [1:0] bonded,
  output logic      [1:0] seq_seen,
  output logic            req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  assign req = req_in;
  // Lane 1 finishes later than lane 0, so bring-up must wait for both
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n || xrst)
    begin
      cnt_r    <= 4'h0;
      done     <= 2'b00;
      seq_seen <= 2'b00;
      bonded   <= 2'b00;
    end
    else
    begin
      cnt_r    <= (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
      done     <= {cnt_r > 4'h6, cnt_r > 4'h3};
      seq_seen <= {2{cnt_r > 4'h8}};
      bonded   <= {2{cnt_r > 4'h9}};
    end
  end
endmodule // lane_ctrl_model
`default_nettype wire

// >>> tb/serial_link_phy_ports_tb_top.sv
// Bench for the physical layer port block
`default_nettype none
module serial_link_phy_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, settings_port_reset, xreq;
  logic        txin_tvalid, txin_tready, txin_tlast, rxout_tvalid, rxout_tready, rxout_tlast;
  logic        host_role_flag, request_issue_permit, long_symbol_mode_flag, retransmit_request;
  logic        bonding_enable_out, transceiver_reset_request, transceiver_reset_out;
  logic [1:0]  htrans, lane_tx_disable, lane_bond_sequence_seen, lane_bonded_flag, transceiver_reset_complete;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv, v;
  logic [63:0] txin_tdata, rxout_tdata, lane_tx_word, lane_rx_word, d0, d1;
  logic [7:0]  txin_tkeep, txin_tuser, rxout_tkeep, rxout_tuser, lane_tx_kchar_flags, lane_rx_kchar_flags, kb;
  logic [7:0]  lane_rx_disparity_fault, lane_rx_decode_fault;
  logic [5:0]  next_packet_index, last_accepted_index, partner_free_slots, local_free_slots, idx, a, sl;
  logic [80:0] q[$];
  int          n_fail = 0, samples_checked = 0, rtc = 0, i, k;

  assign hready = hreadyout;
  serial_link_phy_ports i_dut (.*);
  lane_ctrl_model i_lane (.clk(hclk), .rst_n(hresetn), .xrst(transceiver_reset_out), .req_in(xreq),
    .done(transceiver_reset_complete), .bonded(lane_bonded_flag), .seq_seen(lane_bond_sequence_seen),
    .req(transceiver_reset_request));

  // Lanes share this clock, so rx words need no crossing
  always #25 hclk = ~hclk;
  always @(posedge hclk)
  begin
    if (rxout_tvalid === 1'b1 && rxout_tready === 1'b1)
      q.push_back({rxout_tlast, rxout_tkeep, rxout_tuser, rxout_tdata});
    if (retransmit_request === 1'b1)
      rtc++;
  end

  function automatic logic [63:0] csym(input logic [7:0] t, input logic [5:0] id, input logic [5:0] s);
    return {8'h7c, t, 2'b00, id, 2'b00, s, 32'h0};
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Single word transfer; only the watchdog ends a stuck wait
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, ad, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rx(input logic [7:0] kc, input logic [63:0] w, input logic [7:0] df, input logic [7:0] ef);
    @(posedge hclk);
    {lane_rx_kchar_flags, lane_rx_word, lane_rx_disparity_fault, lane_rx_decode_fault} <= {kc, w, df, ef};
  endtask

  task automatic tx(input logic [63:0] d, input logic [7:0] kp, input logic l, input logic [7:0] u);
    @(posedge hclk);
    {txin_tvalid, txin_tdata, txin_tkeep, txin_tlast, txin_tuser} <= {1'b1, d, kp, l, u};
    do @(negedge hclk); while (txin_tready !== 1'b1);
    @(posedge hclk);
    txin_tvalid <= 1'b0;
  endtask

  task automatic wact();
    k = 0;
    do
    begin
      ahb(1'b0, 32'h4, 32'h0);
      k++;
    end
    while (rdv[1:0] !== 2'b11 && k < 200);
    chk(rdv[3:0], 4'hf);
  endtask

  initial
  begin
    {hclk, hresetn, hsel, hwrite, settings_port_reset, xreq, txin_tvalid, txin_tlast} = '0;
    {htrans, haddr, hwdata, txin_tdata, txin_tkeep, txin_tuser, hsize, sl} = {146'h0, 3'h2, 6'h0};
    {lane_rx_disparity_fault, lane_rx_decode_fault, rxout_tready, local_free_slots} = {16'h0, 1'b1, 6'h1e};
    {lane_rx_kchar_flags, lane_rx_word} = {8'hf0, csym(8'h02, 6'h0, 6'h0)};
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h5c37));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk({rdv, hresp, hreadyout}, {32'h0000_0018, 1'b0, 1'b1});
    ahb(1'b0, 32'h10, 32'h0);
    chk(rdv, 32'h0000_0000);
    for (i = 0; i < 4; i++)
    begin
      v = $urandom & 32'h0000_031f;
      ahb(1'b1, 32'h0, v);
      ahb(1'b0, 32'h0, 32'h0);
      chk({rdv, host_role_flag, request_issue_permit, long_symbol_mode_flag, bonding_enable_out, lane_tx_disable},
          {v, v[0], v[1], v[2], v[4], v[9:8]});
    end
    @(posedge hclk) settings_port_reset <= 1'b1;
    @(posedge hclk) settings_port_reset <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rdv, 32'h0000_0018);
    local_free_slots <= 6'($urandom_range(30));
    wact();
    for (i = 0; i < 2; i++)
    begin
      idx = next_packet_index;
      d0 = {$urandom, $urandom};
      d1 = {$urandom, $urandom};
      tx(d0, 8'hff, 1'b0, 8'h02);
      @(negedge hclk);
      chk({lane_tx_kchar_flags, lane_tx_word}, {8'h00, idx, 1'b1, d0[56:0]});
      tx(d1, 8'h0f, 1'b1, {7'h0, i[0]});
      @(negedge hclk);
      chk({lane_tx_kchar_flags, lane_tx_word}, {8'h00, d1});
      @(negedge hclk);
      chk({lane_tx_kchar_flags, lane_tx_word[63:48]}, {8'h80, i ? 16'hfe00 : 16'hfd0f});
      @(negedge hclk);
      chk(next_packet_index, i ? idx : idx + 6'h1);
    end
    chk({lane_tx_kchar_flags, lane_tx_word[63:48], lane_tx_word[37:32]},
        {8'hf0, 16'h7c02, local_free_slots});
    a = 6'($urandom_range(31));
    sl = 6'($urandom_range(30));
    rx(8'hf0, csym(8'h00, a, 6'h0), 8'h00, 8'h00);
    rx(8'hf0, csym(8'h02, 6'h0, sl), 8'h00, 8'h00);
    repeat (4) @(negedge hclk);
    chk({last_accepted_index, partner_free_slots}, {a, sl});
    rtc = 0;
    rx(8'hf0, csym(8'h01, 6'h0, 6'h0), 8'h00, 8'h00);
    rx(8'hf0, csym(8'h02, 6'h0, sl), 8'h00, 8'h00);
    repeat (4) @(negedge hclk);
    chk({rtc[7:0], next_packet_index}, {8'h01, (a + 6'h1) & 6'h1f});
    for (i = 0; i < 3; i++)
    begin
      q.delete();
      d0 = {$urandom, $urandom};
      d1 = {$urandom, $urandom};
      kb = 8'hff >> $urandom_range(7);
      rx(8'h00, d0, 8'h00, 8'h00);
      rx(8'h00, d1, (i == 1) ? 8'h01 : 8'h00, (i == 2) ? 8'h10 : 8'h00);
      rx(8'h80, {8'hfd, kb, 48'h0}, 8'h00, 8'h00);
      rx(8'hf0, csym(8'h02, 6'h0, sl), 8'h00, 8'h00);
      repeat (5) @(negedge hclk);
      chk(q.size(), 2);
      chk({q[0][80:72], q[0][65], q[0][63:0]}, {9'h0ff, d0[57], d0});
      chk({q[1][80:72], q[1][64], q[1][63:0]}, {1'b1, kb, i != 0, d1});
    end
    for (i = 0; i < 2; i++)
    begin
      if (i == 0)
        ahb(1'b1, 32'h0, 32'h0001_0018);
      else
        @(posedge hclk) xreq <= 1'b1;
      k = 0;
      while (transceiver_reset_out !== 1'b1 && k < 8)
      begin
        @(negedge hclk);
        k++;
      end
      chk(transceiver_reset_out, 1'b1);
      @(posedge hclk) xreq <= 1'b0;
      wact();
    end
    conclude();
  end
endmodule // serial_link_phy_ports_tb_top
`default_nettype wire
